// ---- pkg/pdm_output_map.vh ----
`ifndef PDM_OUTPUT_MAP_VH
`define PDM_OUTPUT_MAP_VH

// register byte offsets
`define OFS_CONTROL            8'h00
`define OFS_CLOCK_PRESCALE     8'h04
`define OFS_CONVERTED_RESULT   8'h14
`define OFS_IRQ_ENABLE_SET     8'h18
`define OFS_IRQ_ENABLE_CLEAR   8'h1C
`define OFS_IRQ_MASK_STATE     8'h20
`define OFS_IRQ_FLAGS          8'h24
`define OFS_FILTER_CONFIG_A    8'h58
`define OFS_GAIN_OFFSET_CONFIG 8'h5C
`define OFS_WRITE_GUARD_MODE   8'hE4
`define OFS_WRITE_GUARD_STATUS 8'hE8

// control fields
`define CTL_SOFT_RESET_BIT     0
`define CTL_ENABLE_BIT         4

// clock prescale mode fields and reset
`define PRESCALE_LSB           8
`define PRESCALE_MSB           14
`define MODE_RESET             32'h00F00000

// flag and mask bit positions
`define FLAG_READY_BIT         24
`define FLAG_OVERRUN_BIT       25

// filter_config_a fields
`define CFG_HP_BYPASS_BIT      1
`define CFG_DROOP_BYPASS_BIT   2
`define CFG_SIZE_BIT           3
`define CFG_OSR_LSB            4
`define CFG_OSR_MSB            6
`define CFG_SCALE_LSB          8
`define CFG_SCALE_MSB          11
`define CFG_SHIFT_LSB          12
`define CFG_SHIFT_MSB          15
`define CFG_A_RESET            32'h00000000

// gain_offset_config fields
`define GAIN_LSB               0
`define GAIN_MSB               14
`define OFFSET_LSB             16
`define OFFSET_MSB             31
`define GAIN_OFFSET_RESET      32'h00000001

// write guard fields
`define GUARD_ENABLE_BIT       0
`define GUARD_KEY_LSB          8
`define GUARD_KEY_MSB          31
`define GUARD_KEY              24'h414443
`define VIOL_SRC_LSB           8
`define VIOL_SRC_MSB           15

// high-pass pole: a = 1 - 2^-9, about 15 Hz at 48 kHz
`define HP_POLE_SHIFT          9

// saturation limits for the 16-bit result
`define SAT_POS                32'h00007FFF
`define SAT_NEG                32'hFFFF8001

`endif

// ---- design/highpass_stage.v ----
`timescale 1ns/10ps
`include "pdm_output_map.vh"

// first-order dc blocker, y = x - x_prev + y_prev - y_prev/512
module highpass_stage (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clear,
    // control
    input wire bypass,
    // sample in
    input wire [23:0] in_value,
    input wire in_strobe,
    // sample out
    output reg [23:0] out_value,
    output reg out_strobe
);
    reg [23:0] x_prev;
    reg [31:0] y_acc;
    wire [31:0] x_ext = {{8{in_value[23]}}, in_value};
    wire [31:0] xp_ext = {{8{x_prev[23]}}, x_prev};
    wire [31:0] leak = $signed(y_acc) >>> `HP_POLE_SHIFT;
    wire [31:0] next_y = y_acc + x_ext - xp_ext - leak;
    reg [23:0] y_sat;

    // clamp to the 24-bit range so a step cannot wrap
    always @* begin
        if ($signed(next_y) > $signed(32'h007FFFFF)) begin
            y_sat = 24'h7FFFFF;
        end else if ($signed(next_y) < $signed(32'hFF800000)) begin
            y_sat = 24'h800000;
        end else begin
            y_sat = next_y[23:0];
        end
    end

    // filter state keeps running in bypass so re-enable is settled
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            x_prev <= 24'h000000;
            y_acc <= 32'h00000000;
            out_value <= 24'h000000;
            out_strobe <= 1'b0;
        end else if (clear) begin
            x_prev <= 24'h000000;
            y_acc <= 32'h00000000;
            out_value <= 24'h000000;
            out_strobe <= 1'b0;
        end else begin
            out_strobe <= in_strobe;
            if (in_strobe) begin
                x_prev <= in_value;
                y_acc <= {{8{y_sat[23]}}, y_sat};
                out_value <= bypass ? in_value : y_sat;
            end
        end
    end
endmodule

// ---- design/pdm_output_stage.v ----
// Summary of operation
// - first-order high-pass, 15 Hz at 48 kHz
// - bypass bit routes filter input straight through
// - out = (x + offset*256)*gain / 2^(scale+shift+8)
// - offset signed 16 bits, times 256
// - gain unsigned 15 bits, keep 32 MSBs
// - scale and shift 4-bit right shifts
// - 32-bit mode skips the shift division
// - 16-bit mode shifts, saturates to +-32767
// - reset settings give 16-bit range results
// - store result, set ready flag
// - ready rising requests dma, can interrupt
// - reading result clears ready flag
// - result while ready sets overrun, drops it
// - status read returns overrun then clears it
// - each result stored while ready is clear triggers dma transfer
// - guard enable blocks mode and dsp writes
// - blocked write flags violation and its source
// - reading guard status clears violation flag
// - soft reset bit resets all but the pin synchroniser, sampled bit and read data, reads zero
// - enable bit starts and stops conversions
// - sample clock = clk / (2*(prescale+1))
// - result register holds until read
// - sample clock from clk/2 to clk/256
// - size bit: 0 is 16-bit, 1 is 32-bit
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "pdm_output_map.vh"

module pdm_output_stage (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rd_data,
    // microphone pins
    output reg bitstream_sample_clock,
    input wire pdm_data_pin,
    // bitstream to decimator
    output reg sampled_bit,
    output reg sampled_bit_strobe,
    // filtered samples from decimator
    input wire [23:0] filtered_value,
    input wire filtered_strobe,
    // peripheral dma channel and interrupt
    output reg dma_request,
    output wire irq
);
    // register state
    reg interface_enable_bit;
    reg [6:0] clock_divider_field;
    reg [31:0] converted_result;
    reg [1:0] irq_mask;
    reg result_ready_flag;
    reg ready_d;
    reg overrun_flag;
    reg highpass_bypass;
    reg droop_bypass;
    reg output_size;
    reg [2:0] osr_select;
    reg [3:0] scale;
    reg [3:0] shift;
    reg [14:0] gain;
    reg [15:0] offset;
    reg write_guard_enable;
    reg write_violation_flag;
    reg [7:0] violation_source;
    reg soft_reset;

    // clock divider and sampler
    reg [6:0] div_count;
    reg pin_meta;
    reg pin_sync;

    // decoded accesses
    wire wr_control = wr_en && (addr == `OFS_CONTROL);
    wire wr_mode = wr_en && (addr == `OFS_CLOCK_PRESCALE);
    wire wr_cfg_a = wr_en && (addr == `OFS_FILTER_CONFIG_A);
    wire wr_gain = wr_en && (addr == `OFS_GAIN_OFFSET_CONFIG);
    wire wr_guard = wr_en && (addr == `OFS_WRITE_GUARD_MODE);
    wire wr_ier = wr_en && (addr == `OFS_IRQ_ENABLE_SET);
    wire wr_idr = wr_en && (addr == `OFS_IRQ_ENABLE_CLEAR);
    wire rd_result = rd_en && (addr == `OFS_CONVERTED_RESULT);
    wire rd_flags = rd_en && (addr == `OFS_IRQ_FLAGS);
    wire rd_guard_status = rd_en && (addr == `OFS_WRITE_GUARD_STATUS);
    wire guarded_hit = wr_mode || wr_cfg_a || wr_gain;
    wire guard_block = write_guard_enable && guarded_hit;
    wire key_ok = (wr_data[`GUARD_KEY_MSB:`GUARD_KEY_LSB] == `GUARD_KEY);

    // soft reset: one-cycle synchronous clear of everything except the pin synchroniser, sampled_bit and rd_data
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= wr_control && wr_data[`CTL_SOFT_RESET_BIT];
        end
    end

    // configuration registers; guarded ones drop writes while protected
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interface_enable_bit <= 1'b0;
            // prescale bits of the mode reset pattern are zero; sized so nothing is cut
            clock_divider_field <= 7'h00;
            highpass_bypass <= 1'b0;
            droop_bypass <= 1'b0;
            output_size <= 1'b0;
            osr_select <= 3'h0;
            scale <= 4'h0;
            shift <= 4'h0;
            gain <= 15'h0001;
            offset <= 16'h0000;
            write_guard_enable <= 1'b0;
            irq_mask <= 2'h0;
        end else if (soft_reset) begin
            interface_enable_bit <= 1'b0;
            clock_divider_field <= 7'h00;
            highpass_bypass <= 1'b0;
            droop_bypass <= 1'b0;
            output_size <= 1'b0;
            osr_select <= 3'h0;
            scale <= 4'h0;
            shift <= 4'h0;
            gain <= 15'h0001;
            offset <= 16'h0000;
            write_guard_enable <= 1'b0;
            irq_mask <= 2'h0;
        end else begin
            if (wr_control && !wr_data[`CTL_SOFT_RESET_BIT]) begin
                interface_enable_bit <= wr_data[`CTL_ENABLE_BIT];
            end
            if (wr_mode && !guard_block) begin
                clock_divider_field <= wr_data[`PRESCALE_MSB:`PRESCALE_LSB];
            end
            if (wr_cfg_a && !guard_block) begin
                highpass_bypass <= wr_data[`CFG_HP_BYPASS_BIT];
                droop_bypass <= wr_data[`CFG_DROOP_BYPASS_BIT];
                output_size <= wr_data[`CFG_SIZE_BIT];
                osr_select <= wr_data[`CFG_OSR_MSB:`CFG_OSR_LSB];
                scale <= wr_data[`CFG_SCALE_MSB:`CFG_SCALE_LSB];
                shift <= wr_data[`CFG_SHIFT_MSB:`CFG_SHIFT_LSB];
            end
            if (wr_gain && !guard_block) begin
                gain <= wr_data[`GAIN_MSB:`GAIN_LSB];
                offset <= wr_data[`OFFSET_MSB:`OFFSET_LSB];
            end
            if (wr_guard && key_ok) begin
                write_guard_enable <= wr_data[`GUARD_ENABLE_BIT];
            end
            if (wr_ier) begin
                irq_mask <= irq_mask | wr_data[`FLAG_OVERRUN_BIT:`FLAG_READY_BIT];
            end else if (wr_idr) begin
                irq_mask <= irq_mask & ~wr_data[`FLAG_OVERRUN_BIT:`FLAG_READY_BIT];
            end
        end
    end

    // violation flag: a new hit wins over the clearing read
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_violation_flag <= 1'b0;
            violation_source <= 8'h00;
        end else if (soft_reset) begin
            write_violation_flag <= 1'b0;
            violation_source <= 8'h00;
        end else if (guard_block) begin
            write_violation_flag <= 1'b1;
            violation_source <= addr;
        end else if (rd_guard_status) begin
            write_violation_flag <= 1'b0;
        end
    end

    // sample clock: toggles every prescale+1 cycles, low while disabled
    wire div_wrap = (div_count == clock_divider_field);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= 7'h00;
            bitstream_sample_clock <= 1'b0;
        end else if (soft_reset || !interface_enable_bit) begin
            div_count <= 7'h00;
            bitstream_sample_clock <= 1'b0;
        end else if (div_wrap) begin
            div_count <= 7'h00;
            bitstream_sample_clock <= ~bitstream_sample_clock;
        end else begin
            div_count <= div_count + 7'h01;
        end
    end

    // pin synchroniser; the sample is taken at our rising clock edge,
    // so microphone delay must fit in one sample clock period less two clk cycles
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            sampled_bit <= 1'b0;
            sampled_bit_strobe <= 1'b0;
        end else begin
            pin_meta <= pdm_data_pin;
            pin_sync <= pin_meta;
            sampled_bit_strobe <= interface_enable_bit && !soft_reset && div_wrap && !bitstream_sample_clock;
            if (interface_enable_bit && div_wrap && !bitstream_sample_clock) begin
                sampled_bit <= pin_sync;
            end
        end
    end

    // high-pass stage after the low-pass filter
    wire [23:0] hp_value;
    wire hp_strobe;
    highpass_stage u_highpass (
        .clk(clk),
        .reset_n(reset_n),
        .clear(soft_reset),
        .bypass(highpass_bypass),
        .in_value(filtered_value),
        .in_strobe(filtered_strobe && interface_enable_bit),
        .out_value(hp_value),
        .out_strobe(hp_strobe)
    );

    // compensation datapath; one multiplier, done in the cycle after filtering
    wire [24:0] biased = {hp_value[23], hp_value} + {offset[15], offset, 8'h00};
    wire [40:0] product = $signed(biased) * $signed({1'b0, gain});
    wire [31:0] top32 = product[39:8];
    wire [31:0] scaled = $signed(top32) >>> scale;
    wire [31:0] shifted = $signed(scaled) >>> shift;
    reg [31:0] result_value;
    always @* begin
        if (output_size) begin
            result_value = scaled;
        end else if ($signed(shifted) > $signed(`SAT_POS)) begin
            result_value = {16'h0000, 16'h7FFF};
        end else if ($signed(shifted) < $signed(`SAT_NEG)) begin
            result_value = {16'h0000, 16'h8001};
        end else begin
            result_value = {16'h0000, shifted[15:0]};
        end
    end

    // result register and flags; a read in the same cycle frees the slot
    wire slot_free = !result_ready_flag || rd_result;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            converted_result <= 32'h00000000;
            result_ready_flag <= 1'b0;
            overrun_flag <= 1'b0;
            ready_d <= 1'b0;
            dma_request <= 1'b0;
        end else if (soft_reset) begin
            converted_result <= 32'h00000000;
            result_ready_flag <= 1'b0;
            overrun_flag <= 1'b0;
            ready_d <= 1'b0;
            dma_request <= 1'b0;
        end else begin
            ready_d <= result_ready_flag;
            dma_request <= result_ready_flag && !ready_d;
            if (hp_strobe && slot_free) begin
                converted_result <= result_value;
                result_ready_flag <= 1'b1;
            end else if (rd_result) begin
                result_ready_flag <= 1'b0;
            end
            if (hp_strobe && !slot_free) begin
                overrun_flag <= 1'b1;
            end else if (rd_flags) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // interrupt line from enabled flags
    assign irq = (result_ready_flag && irq_mask[0]) || (overrun_flag && irq_mask[1]);

    // read mux, registered one cycle after the strobe
    reg [31:0] next_rd_data;
    always @* begin
        case (addr)
            `OFS_CONTROL: next_rd_data = {27'h0000000, interface_enable_bit, 4'h0};
            `OFS_CLOCK_PRESCALE:
                next_rd_data = `MODE_RESET | {17'h00000, clock_divider_field, 8'h00};
            `OFS_CONVERTED_RESULT: next_rd_data = converted_result;
            `OFS_IRQ_MASK_STATE: next_rd_data = {6'h00, irq_mask, 24'h000000};
            `OFS_IRQ_FLAGS: next_rd_data = {6'h00, overrun_flag, result_ready_flag, 24'h000000};
            `OFS_FILTER_CONFIG_A:
                next_rd_data = {16'h0000, shift, scale, 1'b0, osr_select, output_size, droop_bypass,
                                highpass_bypass, 1'b0};
            `OFS_GAIN_OFFSET_CONFIG: next_rd_data = {offset, 1'b0, gain};
            `OFS_WRITE_GUARD_MODE: next_rd_data = {31'h00000000, write_guard_enable};
            `OFS_WRITE_GUARD_STATUS:
                next_rd_data = {16'h0000, violation_source, 7'h00, write_violation_flag};
            default: next_rd_data = 32'h00000000;
        endcase
    end

    // read data is valid only in the cycle after the strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 32'h00000000;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 32'h00000000;
        end
    end
endmodule

// ---- dv/pdm_mic_model.sv ----
`timescale 1ns/10ps
module pdm_mic_model (
    // sample clock from the controller
    input wire sample_clock,
    // bitstream towards the controller
    output reg data_out
);
    reg [7:0] pattern;

    // start from a known stream so runs repeat exactly
    initial begin
        pattern = 8'hA5;
        data_out = 1'b0;
    end

    // new bit after each rising clock, a stopped clock freezes it
    always @(posedge sample_clock) begin
        pattern <= {pattern[6:0], pattern[7] ^ pattern[5]};
        data_out <= #5 pattern[0]; // late launch, as a real part
    end
endmodule

// ---- dv/pdm_output_stage_chk.sv ----
`timescale 1ns/10ps
`include "pdm_output_map.vh"
module pdm_output_stage_chk (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [7:0] addr,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rd_data,
    // microphone and stream
    input wire bitstream_sample_clock,
    input wire sampled_bit_strobe,
    input wire filtered_strobe,
    // dma
    input wire dma_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    reg [2:0] strb_hist;
    reg prev_rd;
    reg [7:0] prev_addr;

    // history, so flag reads are judged only with no result in flight
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strb_hist <= 3'h0;
            prev_rd <= 1'b0;
            prev_addr <= 8'h00;
        end else begin
            strb_hist <= {strb_hist[1:0], filtered_strobe};
            prev_rd <= rd_en;
            prev_addr <= addr;
        end
    end

    property p_dma_pulse;
        dma_request |=> !dma_request;
    endproperty
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma request longer than one cycle");
    property p_dma_cause;
        dma_request |-> $past(filtered_strobe, 3);
    endproperty
    a_dma_cause: assert property (p_dma_cause) else $error("dma request without a stored result");
    property p_strobe_rise;
        $rose(bitstream_sample_clock) |-> ##[0:1] sampled_bit_strobe;
    endproperty
    a_strobe_rise: assert property (p_strobe_rise) else $error("no bit sampled at clock rise");
    property p_half_period;
        $rose(bitstream_sample_clock) |-> ##[1:128] !bitstream_sample_clock;
    endproperty
    a_half_period: assert property (p_half_period) else $error("sample clock high too long");
    property p_soft_reset_bit_zero;
        rd_en && addr == `OFS_CONTROL |=> rd_data[3:0] == 4'h0;
    endproperty
    a_soft_reset_bit_zero: assert property (p_soft_reset_bit_zero) else $error("soft reset bit reads one");
    property p_ready_clear;
        rd_en && addr == `OFS_IRQ_FLAGS && prev_rd && prev_addr == `OFS_CONVERTED_RESULT && strb_hist == 3'h0
            |=> !rd_data[`FLAG_READY_BIT];
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready flag survives result read");
    property p_ovr_clear;
        rd_en && addr == `OFS_IRQ_FLAGS && prev_rd && prev_addr == `OFS_IRQ_FLAGS && strb_hist == 3'h0
            |=> !rd_data[`FLAG_OVERRUN_BIT];
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun survives status read");
    property p_viol_clear;
        rd_en && addr == `OFS_WRITE_GUARD_STATUS && prev_rd && prev_addr == `OFS_WRITE_GUARD_STATUS |=> !rd_data[0];
    endproperty
    a_viol_clear: assert property (p_viol_clear) else $error("violation flag survives read");

    c_dma: cover property (dma_request);
    c_clock: cover property ($rose(bitstream_sample_clock));
    c_guard: cover property (rd_en && addr == `OFS_WRITE_GUARD_STATUS);
endmodule

bind pdm_output_stage pdm_output_stage_chk chk_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .bitstream_sample_clock(bitstream_sample_clock),
    .sampled_bit_strobe(sampled_bit_strobe), .filtered_strobe(filtered_strobe), .dma_request(dma_request));

// ---- dv/pdm_output_stage_tb.sv ----
`timescale 1ns/10ps
`include "pdm_output_map.vh"
module pdm_output_stage_tb;
    reg clk, reset_n, wr_en, rd_en, filtered_strobe;
    reg [7:0] addr;
    reg [31:0] wr_data, d1, d2;
    reg [23:0] filtered_value;
    wire [31:0] rd_data;
    wire mic_clk, mic_dat, sbit, sbit_strobe, dma_request, irq;
    integer errors, checked, cycles, dmas, t;

    pdm_output_stage dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .bitstream_sample_clock(mic_clk), .pdm_data_pin(mic_dat),
        .sampled_bit(sbit), .sampled_bit_strobe(sbit_strobe), .filtered_value(filtered_value),
        .filtered_strobe(filtered_strobe), .dma_request(dma_request), .irq(irq));
    pdm_mic_model mic_u (.sample_clock(mic_clk), .data_out(mic_dat));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // dma pulses and a hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (dma_request === 1'b1)
            dmas = dmas + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            wrap_up;
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // bus tasks start just after an edge and leave one idle edge
    task wr(input [7:0] a, input [31:0] d);
        begin
            addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
            @(posedge clk);
        end
    endtask

    // two reads back to back, data taken mid-cycle after each
    task rd2(input [7:0] a1, input [7:0] a2, output [31:0] x1, output [31:0] x2);
        begin
            addr <= a1;
            rd_en <= 1'b1;
            @(posedge clk);
            addr <= a2;
            @(negedge clk);
            x1 = rd_data;
            @(posedge clk);
            rd_en <= 1'b0;
            @(negedge clk);
            x2 = rd_data;
            @(posedge clk);
        end
    endtask

    task rchk(input [7:0] a, input [31:0] exp);
        begin
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            @(negedge clk);
            check(rd_data, exp);
            @(posedge clk);
        end
    endtask

    // one filtered sample; result stored and dma done when this returns
    task conv(input [23:0] v);
        begin
            filtered_value <= v;
            filtered_strobe <= 1'b1;
            @(posedge clk);
            filtered_strobe <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // offset, gain, scale, shift and size worked out from the settings
    function [31:0] model_out(input [23:0] x, input [31:0] ca, input [31:0] cg);
        reg signed [47:0] p;
        reg signed [31:0] r;
        begin
            p = ($signed({{24{x[23]}}, x}) + $signed({{24{cg[31]}}, cg[31:16], 8'h00})) * $signed({33'h0, cg[14:0]});
            r = p[39:8];
            r = r >>> ca[11:8];
            if (ca[3]) begin
                model_out = r;
            end else begin
                r = r >>> ca[15:12];
                if (r > 32767)
                    r = 32767;
                if (r < -32767)
                    r = -32767;
                model_out = {16'h0, r[15:0]};
            end
        end
    endfunction

    task run_case(input [31:0] ca, input [31:0] cg, input [23:0] x);
        begin
            wr(`OFS_FILTER_CONFIG_A, ca);
            wr(`OFS_GAIN_OFFSET_CONFIG, cg);
            t = dmas;
            conv(x);
            check(dmas - t, 1);
            rchk(`OFS_CONVERTED_RESULT, model_out(x, ca, cg));
        end
    endtask

    task wrap_up;
        begin
            $display("checked=%0d errors=%0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    initial begin
        {errors, checked, cycles, dmas} = 0;
        {reset_n, wr_en, rd_en, filtered_strobe, addr, wr_data, filtered_value} = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rchk(`OFS_CONTROL, 32'h00000000);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00000);
        rchk(`OFS_CONVERTED_RESULT, 32'h00000000);
        rchk(`OFS_IRQ_MASK_STATE, 32'h00000000);
        rchk(`OFS_IRQ_FLAGS, 32'h00000000);
        rchk(`OFS_FILTER_CONFIG_A, 32'h00000000);
        rchk(`OFS_GAIN_OFFSET_CONFIG, 32'h00000001);
        rchk(`OFS_WRITE_GUARD_MODE, 32'h00000000);
        rchk(`OFS_WRITE_GUARD_STATUS, 32'h00000000);
        rchk(8'h08, 32'h00000000);
        $display("reset values done");
        // dc step through the high-pass, clean filter state
        wr(`OFS_CONTROL, 32'h00000010);
        conv(24'h100000);
        rchk(`OFS_CONVERTED_RESULT, 32'h00001000);
        conv(24'h100000);
        rchk(`OFS_CONVERTED_RESULT, 32'h00000FF8);
        $display("high-pass done");
        wr(`OFS_CLOCK_PRESCALE, 32'h00000200);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00200);
        t = 0;
        repeat (60) begin
            @(negedge clk);
            if (sbit_strobe === 1'b1)
                t = t + 1;
        end
        @(posedge clk);
        check(t, 10);
        $display("sample clock done");
        run_case(32'h00000002, 32'h00000001, 24'h123456);
        run_case(32'h00000002, 32'h00000001, 24'hFEDCBA);
        run_case(32'h00000002, 32'h00007FFF, 24'h7FFFFF);
        run_case(32'h00000002, 32'h00007FFF, 24'h800000);
        run_case(32'h00003302, 32'hFF800010, 24'h012345);
        run_case(32'h0000F80A, 32'h00000100, 24'h400000);
        run_case(32'h0000000A, 32'h00000001, 24'hABCDEF);
        $display("arithmetic done");
        wr(`OFS_FILTER_CONFIG_A, 32'h00000002);
        t = dmas;
        conv(24'h010000);
        conv(24'h020000);
        check(dmas - t, 1);
        // back-to-back status reads: the second must see overrun gone
        rd2(`OFS_IRQ_FLAGS, `OFS_IRQ_FLAGS, d1, d2);
        check(d1, 32'h03000000);
        check(d2, 32'h01000000);
        rd2(`OFS_IRQ_FLAGS, `OFS_CONVERTED_RESULT, d1, d2);
        check(d1, 32'h01000000);
        check(d2, 32'h00000100);
        rd2(`OFS_CONVERTED_RESULT, `OFS_IRQ_FLAGS, d1, d2);
        check(d2, 32'h00000000);
        $display("flags done");
        wr(`OFS_IRQ_ENABLE_SET, 32'h01000000);
        conv(24'h030000);
        check(irq, 1);
        rchk(`OFS_CONVERTED_RESULT, 32'h00000300);
        check(irq, 0);
        wr(`OFS_IRQ_ENABLE_CLEAR, 32'h01000000);
        $display("interrupt done");
        wr(`OFS_CONTROL, 32'h00000000);
        t = dmas;
        conv(24'h040000);
        check(dmas - t, 0);
        check(mic_clk, 0);
        rchk(`OFS_IRQ_FLAGS, 32'h00000000);
        $display("disable done");
        wr(`OFS_WRITE_GUARD_MODE, 32'h41444301);
        wr(`OFS_CLOCK_PRESCALE, 32'h00000500);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00200);
        // the read clears only the flag; the source field keeps its value
        rd2(`OFS_WRITE_GUARD_STATUS, `OFS_WRITE_GUARD_STATUS, d1, d2);
        check(d1, 32'h00000401);
        check(d2, 32'h00000400);
        wr(`OFS_FILTER_CONFIG_A, 32'h00000008);
        wr(`OFS_GAIN_OFFSET_CONFIG, 32'h00000005);
        rchk(`OFS_FILTER_CONFIG_A, 32'h00000002);
        rchk(`OFS_GAIN_OFFSET_CONFIG, 32'h00000001);
        rchk(`OFS_WRITE_GUARD_STATUS, 32'h00005C01);
        wr(`OFS_WRITE_GUARD_MODE, 32'h00000000);
        wr(`OFS_CLOCK_PRESCALE, 32'h00000500);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00200);
        wr(`OFS_WRITE_GUARD_MODE, 32'h41444300);
        wr(`OFS_CLOCK_PRESCALE, 32'h00000500);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00500);
        $display("write guard done");
        wr(`OFS_CONTROL, 32'h00000011);
        rchk(`OFS_CLOCK_PRESCALE, 32'h00F00000);
        rchk(`OFS_CONTROL, 32'h00000000);
        $display("soft reset done");
        wrap_up;
    end
endmodule
